//--- sesr_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef SESR_REGS_SVH
`define SESR_REGS_SVH
// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define SESR_OFS_ALIGN    4'h7
`define SESR_OFS_SNAPLO   4'h7
`define SESR_OFS_CTRL     4'hb
`define SESR_OFS_GATE     4'he
`define SESR_OFS_FLAGS    4'hf
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SESR_BIT_ALIGN    0
`define SESR_BIT_LATCH    1
`define SESR_BIT_MISSED   3
`define SESR_RST_GATE     8'hff
`define SESR_RST_CTRL     8'h00
`define SESR_RST_SNAP     12'h000
// ----------------------------------------------------------------
// timing: output periods in ns at a 20 ns clock
// ----------------------------------------------------------------
`define SESR_CLK_NS       20
`define SESR_PER0_NS      125000
`define SESR_PER0_CYC     (`SESR_PER0_NS / `SESR_CLK_NS)
`endif

//--- sesr_pkg.sv
// types shared by the register group
package sesr_pkg;
   typedef logic [7:0]  sesr_byte_t;
   typedef logic [11:0] sesr_cnt_t;
   typedef logic [1:0]  sesr_rate_t;
endpackage

//--- sesr_period.sv
// output period timer with missed-read detection
`timescale 1ns/10ps
`include "sesr_regs.svh"
module sesr_period #(
   parameter int BASE_CYC = `SESR_PER0_CYC
) (
   input  wire logic                mclk,
   input  wire logic                rst_n,
   input  wire sesr_pkg::sesr_rate_t rate,
   input  wire logic                align,
   input  wire logic                outputs_read,
   output logic                     period_tick,
   output logic                     missed
);
   logic [17:0] cnt_r;
   logic        read_seen_r;
   logic [17:0] limit;
   // longest period is eight times the base period
   assign limit = 18'(BASE_CYC << rate) - 18'h0_0001;
   wire wrap = (cnt_r >= limit);
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r       <= 18'h0_0000;
         read_seen_r <= 1'b0;
         period_tick <= 1'b0;
         missed      <= 1'b0;
      end else begin
         // align restarts the period at once across devices
         cnt_r       <= (align || wrap) ? 18'h0_0000 : cnt_r + 18'h0_0001; // R01 R11
         period_tick <= wrap;
         missed      <= wrap && !read_seen_r && !outputs_read; // R07
         read_seen_r <= wrap ? 1'b0 : (read_seen_r | outputs_read);
      end
   end
endmodule

//--- sesr_top.sv
// register group: align/latch control, pulse slot gating, status flags
`timescale 1ns/10ps
`include "sesr_regs.svh"
// Overview of operation
// (R01) writing one to control bit 0 aligns outputs; bit self-clears next cycle
// (R02) writing one to control bit 1 latches counters; bit self-clears next cycle
// (R03) host sets these bits by one broadcast write reaching all devices
// (R04) control bits 7 to 2 do nothing and reset to zero
// (R05) gating bit n enables the converter pulse in slot n of clock/4
// (R06) all gating bits reset to one
// (R07) unread outputs over one period set missed-read flag, status bit 3
// (R08) reading the status register clears the missed-read flag
// (R09) status bits 7 to 4 reserved, read zero, reset zero
// (R10) latch request captures 12-bit counter into snapshot bits 11 to 0
// (R11) output period follows rate code: 125, 250, 500 us or 1 ms
// (R12) control action bits read zero except in the cycle before clearing
module sesr_top #(
   parameter sesr_pkg::sesr_byte_t VERSION = 8'h01, // arbitrary value
   parameter int BASE_CYC = `SESR_PER0_CYC
) (
   input  wire logic                 mclk,
   input  wire logic                 rstn,
   input  wire logic                 wr_en,
   input  wire logic                 rd_en,
   input  wire logic [3:0]           addr,
   input  wire sesr_pkg::sesr_byte_t wdata,
   input  wire sesr_pkg::sesr_rate_t output_rate_select,
   input  wire logic                 outputs_read,
   output sesr_pkg::sesr_byte_t      rdata,
   output sesr_pkg::sesr_cnt_t       latched_counter_value,
   output logic                      pwm_pulse,
   output logic                      align_pulse
);
   // ----------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------
   logic rst_s1_r;
   logic rst_n_r;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   wire wr_ctrl  = wr_en && (addr == `SESR_OFS_CTRL);
   wire wr_gate  = wr_en && (addr == `SESR_OFS_GATE);
   wire rd_flags = rd_en && (addr == `SESR_OFS_FLAGS);
   logic [1:0]           ctrl_r;
   sesr_pkg::sesr_byte_t pulse_slot_gating_r;
   logic                 missed_read_flag_r;
   logic [11:0]          free_cnt_r;
   logic [4:0]           slot_cnt_r;
   logic                 period_tick;
   logic                 missed;
   // ----------------------------------------------------------------
   // control: action bits live one cycle, upper bits not stored
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_r <= 2'b00;
      end else begin
         ctrl_r <= wr_ctrl ? wdata[1:0] : 2'b00; // R01 R02 R04 R12
      end
   end
   // ----------------------------------------------------------------
   // gating and counters
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pulse_slot_gating_r   <= `SESR_RST_GATE; // R06
         free_cnt_r            <= 12'h000;
         slot_cnt_r            <= 5'h00;
         latched_counter_value <= `SESR_RST_SNAP;
      end else begin
         if (wr_gate) begin
            pulse_slot_gating_r <= wdata;
         end
         free_cnt_r <= ctrl_r[`SESR_BIT_ALIGN] ? 12'h000
                                               : free_cnt_r + 12'h001;
         // slots advance on clock/4: 8 slots of 4 clocks each
         slot_cnt_r <= ctrl_r[`SESR_BIT_ALIGN] ? 5'h00
                                               : slot_cnt_r + 5'h01;
         if (ctrl_r[`SESR_BIT_LATCH]) begin
            latched_counter_value <= free_cnt_r; // R02 R10
         end
      end
   end
   wire [2:0] slot = slot_cnt_r[4:2];
   // ----------------------------------------------------------------
   // period timer
   // ----------------------------------------------------------------
   sesr_period #(
      .BASE_CYC(BASE_CYC)
   ) u_period (
      .mclk        (mclk),
      .rst_n       (rst_n_r),
      .rate        (output_rate_select),
      .align       (ctrl_r[`SESR_BIT_ALIGN]),
      .outputs_read(outputs_read),
      .period_tick (period_tick),
      .missed      (missed)
   );
   // ----------------------------------------------------------------
   // missed-read flag: a new miss beats the read clear
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         missed_read_flag_r <= 1'b0;
      end else if (missed) begin
         missed_read_flag_r <= 1'b1; // R07
      end else if (rd_flags) begin
         missed_read_flag_r <= 1'b0; // R08
      end
   end
   // ----------------------------------------------------------------
   // read mux and outputs
   // ----------------------------------------------------------------
   wire [7:0] ctrl_rd  = {6'h00, ctrl_r}; // R04 R12
   wire [7:0] flag_rd  = {4'h0, missed_read_flag_r, VERSION[2:0]}; // R09
   wire [7:0] rd_mux   = (addr == `SESR_OFS_CTRL)  ? ctrl_rd :
                         (addr == `SESR_OFS_GATE)  ? pulse_slot_gating_r :
                         (addr == `SESR_OFS_FLAGS) ? flag_rd :
                         (addr == `SESR_OFS_SNAPLO) ?
                            {4'h0, latched_counter_value[11:8]} : 8'h00;
   wire       pwm_gate_first = pulse_slot_gating_r[0];
   wire       pwm_nxt  = pulse_slot_gating_r[slot]; // R05
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata       <= 8'h00;
         pwm_pulse   <= 1'b0;
         align_pulse <= 1'b0;
      end else begin
         rdata       <= rd_en ? rd_mux : 8'h00;
         pwm_pulse   <= pwm_nxt && (slot_cnt_r[1:0] == 2'b00);
         align_pulse <= ctrl_r[`SESR_BIT_ALIGN] | period_tick; // R01
      end
   end
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_ctrl_write_idle;
      wr_ctrl ##1 !wr_ctrl;
   endsequence
   sequence s_gate_open;
      slot_cnt_r[1:0] == 2'b00 && pulse_slot_gating_r[slot];
   endsequence
   sequence s_gate_shut;
      slot_cnt_r[1:0] == 2'b00 && !pulse_slot_gating_r[slot];
   endsequence
   wire [3:0] snap_hi = latched_counter_value[11:8];
   // ----------------------------------------------------------------
   // checks: control and snapshot
   // ----------------------------------------------------------------
   a_ctrl_selfclear: assert property ( // R01
      @(posedge mclk) disable iff (!rst_n_r)
      s_ctrl_write_idle |=> ctrl_r == 2'b00)
      else $error("control bits did not clear");
   a_ctrl_capture: assert property ( // R02
      @(posedge mclk) disable iff (!rst_n_r)
      wr_ctrl |=> {6'h00, ctrl_r} == ($past(wdata) & 8'h03))
      else $error("control bits not taken from write");
   a_align_out: assert property ( // R01
      @(posedge mclk) disable iff (!rst_n_r)
      ctrl_r[`SESR_BIT_ALIGN] |=> align_pulse)
      else $error("align request gave no output pulse");
   a_align_restart: assert property ( // R01
      @(posedge mclk) disable iff (!rst_n_r)
      ctrl_r[`SESR_BIT_ALIGN] |=> slot_cnt_r == 5'h00 && free_cnt_r == 12'h000)
      else $error("align request did not restart counters");
   a_latch_capture: assert property ( // R10
      @(posedge mclk) disable iff (!rst_n_r)
      ctrl_r[1] |=> latched_counter_value == $past(free_cnt_r))
      else $error("counter not latched");
   a_latch_hold: assert property ( // R10
      @(posedge mclk) disable iff (!rst_n_r)
      !ctrl_r[`SESR_BIT_LATCH] |=> $stable(latched_counter_value))
      else $error("snapshot moved without a latch request");
   a_snap_read: assert property ( // R10
      @(posedge mclk) disable iff (!rst_n_r)
      rd_en && addr == `SESR_OFS_SNAPLO |=> rdata == {4'h0, $past(snap_hi)})
      else $error("snapshot read wrong");
   a_ctrl_rsvd: assert property ( // R04
      @(posedge mclk) disable iff (!rst_n_r)
      $past(rd_en) && $past(addr) == `SESR_OFS_CTRL |-> rdata[7:2] == 6'h00)
      else $error("reserved control bits set");
   // ----------------------------------------------------------------
   // checks: missed-read flag
   // ----------------------------------------------------------------
   a_flag_clear: assert property ( // R08
      @(posedge mclk) disable iff (!rst_n_r)
      rd_flags && !missed |=> !missed_read_flag_r)
      else $error("flag not cleared by read");
   a_flag_set: assert property ( // R07
      @(posedge mclk) disable iff (!rst_n_r)
      missed |=> missed_read_flag_r)
      else $error("flag not set");
   a_flag_hold: assert property ( // R07
      @(posedge mclk) disable iff (!rst_n_r)
      missed_read_flag_r && !rd_flags |=> missed_read_flag_r)
      else $error("flag dropped without a read");
   a_flag_quiet: assert property ( // R07
      @(posedge mclk) disable iff (!rst_n_r)
      !missed_read_flag_r && !missed |=> !missed_read_flag_r)
      else $error("flag set without a miss");
   a_miss_tick: assert property ( // R11
      @(posedge mclk) disable iff (!rst_n_r)
      missed |-> period_tick)
      else $error("miss reported off a period boundary");
   a_flag_rsvd: assert property ( // R09
      @(posedge mclk) disable iff (!rst_n_r)
      $past(rd_en) && $past(addr) == `SESR_OFS_FLAGS |-> rdata[7:4] == 4'h0)
      else $error("reserved status bits set");
   // ----------------------------------------------------------------
   // checks: pulse slot gating
   // ----------------------------------------------------------------
   a_gate_pulse: assert property ( // R05
      @(posedge mclk) disable iff (!rst_n_r)
      slot_cnt_r[1:0] == 2'b00 && !pwm_gate_first && slot == 3'h0
      |=> !pwm_pulse)
      else $error("pulse in gated slot");
   a_gate_open: assert property ( // R05
      @(posedge mclk) disable iff (!rst_n_r)
      s_gate_open |=> pwm_pulse)
      else $error("no pulse in an open slot");
   a_gate_shut: assert property ( // R05
      @(posedge mclk) disable iff (!rst_n_r)
      s_gate_shut |=> !pwm_pulse)
      else $error("pulse in a closed slot");
   a_gate_write: assert property ( // R05
      @(posedge mclk) disable iff (!rst_n_r)
      wr_gate |=> pulse_slot_gating_r == $past(wdata))
      else $error("gating write not taken");
   a_gate_hold: assert property ( // R06
      @(posedge mclk) disable iff (!rst_n_r)
      !wr_gate |=> $stable(pulse_slot_gating_r))
      else $error("gating changed without a write");
   a_gate_read: assert property ( // R05
      @(posedge mclk) disable iff (!rst_n_r)
      rd_en && addr == `SESR_OFS_GATE |=> rdata == $past(pulse_slot_gating_r))
      else $error("gating read wrong");
   a_gate_reset: assert property ( // R06
      @(posedge mclk)
      $rose(rst_n_r) |-> pulse_slot_gating_r == `SESR_RST_GATE)
      else $error("gating reset value wrong");
endmodule

//--- sesr_host.sv
// host model that drives the register strobes
`timescale 1ns/10ps
module sesr_host (
   input  wire logic                 mclk,
   input  wire sesr_pkg::sesr_byte_t rdata,
   output logic                      wr_en,
   output logic                      rd_en,
   output logic [3:0]                addr,
   output sesr_pkg::sesr_byte_t      wdata
);
   initial begin
      {wr_en, rd_en, addr, wdata} = 14'h0000;
   end
   // released lines show the inverse so stale values cannot pass
   task automatic wr(input logic [3:0] a, input sesr_pkg::sesr_byte_t d);
      @(negedge mclk);
      {wr_en, addr, wdata} = {1'b1, a, d};
      @(negedge mclk);
      {wr_en, addr, wdata} = {1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [3:0] a, output sesr_pkg::sesr_byte_t d);
      @(negedge mclk);
      {rd_en, addr} = {1'b1, a};
      @(negedge mclk);
      d = rdata;
      {rd_en, addr} = {1'b0, ~a};
   endtask
endmodule

//--- sync_emi_status_regs_test.sv
// self-checking bench for the register group
`timescale 1ns/10ps
`define CHK(g, e) begin \
   check_count++; \
   if ((g) !== (e)) begin \
      err_count++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
   end \
end
module sync_emi_status_regs_test;
   localparam int BASE = 16;
   logic                 mclk = 1'b0;
   logic                 rstn, feed, outputs_read, hit;
   logic                 wr_en, rd_en, pwm_pulse, align_pulse;
   logic [3:0]           addr;
   sesr_pkg::sesr_byte_t wdata, rdata, d, m;
   sesr_pkg::sesr_rate_t rate;
   sesr_pkg::sesr_cnt_t  lcv, v1;
   int                   err_count = 0;
   int                   check_count = 0;
   int                   n, k, cnt;
   integer               seed = 32'ha486e345;
   sesr_top #(.VERSION(8'h01), .BASE_CYC(BASE)) i_sesr_top (
      .mclk(mclk), .rstn(rstn), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wdata(wdata), .output_rate_select(rate),
      .outputs_read(outputs_read), .rdata(rdata),
      .latched_counter_value(lcv), .pwm_pulse(pwm_pulse),
      .align_pulse(align_pulse));
   sesr_host i_sesr_host (.mclk(mclk), .rdata(rdata), .wr_en(wr_en),
      .rd_en(rd_en), .addr(addr), .wdata(wdata));
   always #10 mclk = ~mclk;
   // toggling read strobe keeps every output period serviced once feed is set
   always @(negedge mclk) outputs_read <= feed & ~outputs_read;
   function automatic int ones(input sesr_pkg::sesr_byte_t v);
      return $countones(v);
   endfunction
   task automatic wait_align(output int c);
      c = 0;
      do begin
         @(negedge mclk);
         c++;
      end while (align_pulse !== 1'b1 && c < 300);
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #(20 * 20000);
      err_count++;
      final_report();
   end
   initial begin
      {rstn, feed, outputs_read, rate} = 5'h03;
      repeat (16) @(negedge mclk);
      rstn = 1'b1;
      repeat (4) @(negedge mclk);
      i_sesr_host.rd(4'hb, d); `CHK(d, 8'h00)
      i_sesr_host.rd(4'he, d); `CHK(d, 8'hff)
      i_sesr_host.rd(4'hf, d); `CHK(d[7:4], 4'h0)
      i_sesr_host.wr(4'hb, 8'hff);
      repeat (2) @(negedge mclk);
      i_sesr_host.rd(4'hb, d); `CHK(d, 8'h00)
      // ----------------------------------------------------------
      // align request and counter latch
      // ----------------------------------------------------------
      i_sesr_host.wr(4'hb, 8'h01);
      hit = 1'b0;
      for (int i = 0; i < 3; i++) begin
         hit |= align_pulse;
         @(negedge mclk);
      end
      `CHK(hit, 1'b1)
      k = 3 + ($random(seed) & 15);
      i_sesr_host.wr(4'hb, 8'h02);
      repeat (k) @(negedge mclk);
      v1 = lcv;
      i_sesr_host.wr(4'hb, 8'h02);
      repeat (3) @(negedge mclk);
      `CHK(sesr_pkg::sesr_cnt_t'(lcv - v1), 12'(k + 2))
      i_sesr_host.rd(4'h7, d);
      `CHK(d, {4'h0, 4'((v1 + 12'(k + 2)) >> 8)})
      // ----------------------------------------------------------
      // pulse slot gating, window kept inside one long period
      // ----------------------------------------------------------
      for (int i = 0; i < 5; i++) begin
         m = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
         i_sesr_host.wr(4'he, m);
         i_sesr_host.wr(4'hb, 8'h01);
         i_sesr_host.rd(4'he, d); `CHK(d, m)
         cnt = 0;
         repeat (32) begin
            @(negedge mclk);
            cnt += int'(pwm_pulse === 1'b1);
         end
         `CHK(cnt, ones(m))
      end
      // ----------------------------------------------------------
      // output period per rate code, missed-read flag
      // ----------------------------------------------------------
      for (int r = 0; r < 4; r++) begin
         rate = 2'(r);
         repeat (3) wait_align(n);
         `CHK(n, BASE << r)
      end
      rate = 2'($random(seed) & 3);
      repeat (3 * (BASE << rate)) @(negedge mclk);
      i_sesr_host.rd(4'hf, d); `CHK(d[3], 1'b1)
      feed = 1'b1;
      repeat (2 * (BASE << rate) + 4) @(negedge mclk);
      i_sesr_host.rd(4'hf, d);
      repeat (2 * (BASE << rate) + 4) @(negedge mclk);
      i_sesr_host.rd(4'hf, d); `CHK(d[3], 1'b0)
      final_report();
   end
endmodule
